//--- src/rx_baseband_control_defines.vh
// Purpose: shared constants for the receive baseband control block
// Assumes: 250 MHz system clock, 32-bit register port
// Notes:   register offsets are word indexes on the plain register port
`ifndef RX_BASEBAND_CONTROL_DEFINES_VH
`define RX_BASEBAND_CONTROL_DEFINES_VH

// register offsets
`define REG_OPERATING_MODE      4'h0
`define REG_BIT_RATE            4'h1
`define REG_CORRECTION_CONTROL  4'h2
`define REG_FREQ_ERROR_RESULT   4'h3
`define REG_CORRECTION_VALUE    4'h4
`define REG_CORRECTION_MODE     4'h5
`define REG_LOW_INDEX_OFFSET    4'h6
`define REG_CARRIER_FREQ        4'h7
`define REG_TEMPERATURE         4'h8
`define REG_TIMEOUT             4'h9
`define REG_STATUS              4'hA
`define REG_BANDWIDTH           4'hB

// operating mode field codes
`define MODE_SLEEP              3'h0
`define MODE_STANDBY            3'h1
`define MODE_SYNTH              3'h2
`define MODE_TRANSMIT           3'h3
`define MODE_RECEIVE            3'h4

// operating mode register fields
`define OPM_MODE_LSB            0
`define OPM_LISTEN_BIT          3
`define OPM_SEQ_OFF_BIT         4
`define OPM_CONTINUOUS_BIT      5
`define OPM_SYNC_OFF_BIT        6

// correction control fields
`define CC_START_BIT            0
`define CC_AUTO_ON_BIT          1
`define CC_AUTO_CLEAR_BIT       2
`define CC_FEI_START_BIT        3
`define CC_TEMP_START_BIT       4
`define CM_LOW_INDEX_BIT        0

// reset values
`define BIT_RATE_RESET          16'h001A
`define BIT_RATE_HIGH_RESET     8'h00
`define BIT_RATE_LOW_RESET      8'h1A
`define CARRIER_RESET           24'hE4_C000
`define OPM_RESET               8'h01
`define TEMP_RESET              8'h80

// timing
`define FEI_BIT_PERIODS         4
`define TIMEOUT_BIT_MULT        16
`define TEMP_LIMIT_NS           100000
`define CLK_PERIOD_NS           4
`define TEMP_CYCLES             (`TEMP_LIMIT_NS / `CLK_PERIOD_NS)
`define SEQ_STEP_CYCLES         16'h0040
`define LOW_INDEX_STEP_HZ       488
`endif

//--- src/bit_period_timer.v
// Purpose: bit period tick generator from the bit-rate divider
// Assumes: divider counts system clocks per bit, zero treated as one
// Notes:   tick is a one-cycle pulse, restarted by clear
`timescale 1ns/100ps
module bit_period_timer (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // control
   input  wire [15:0] divider,
   input  wire        clear,
   // result
   output reg         tick
);
   reg [15:0] count;

   // free running divider so every timer shares one bit clock
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else if (count + 16'h0001 >= divider) begin
         // a due tick beats a realign, else edges one period apart swallow every tick
         count <= 16'h0000;
         tick  <= 1'b1;
      end else if (clear) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule

//--- src/rx_baseband_control.v
// Purpose: receive baseband control: bit sync, error measure, correction, temperature, timeouts, modes
// Assumes: demodulated data and threshold flag arrive asynchronously; phase and temperature come from the converter
// Notes:   register port answers reads one cycle later; unmapped reads return zero
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "rx_baseband_control_defines.vh"

// Notes on behaviour
// - continuous mode puts clean recovered data and clock out; sync can be disabled
// - packet mode always runs the sync; bit rate from high and low bytes
// - measurement launch stores signed two's complement frequency error
// - frequency error measurement lasts four bit periods
// - error in hertz is step size times the signed value
// - finished correction subtracts correction value from carrier frequency setting
// - correction starts on receive entry when auto bit set, else on start bit
// - auto clear discards old correction; otherwise evaluation starts from prior value
// - correction phase uses its own channel filter bandwidth setting
// - low index mode corrects by measured error plus offset code times 488 Hz
// - temperature accepted only in standby or synthesizer; converter reused
// - temperature code falls one step per degree of rising temperature
// - temperature running flag clears within 100 microseconds of start
// - timeout after receive start coefficient times 16 bits without threshold flag
// - timeout after threshold coefficient times 16 bits from threshold flag
// - mode field selects sleep, standby, synthesizer, transmit, receive unless listen
// - sequencer steps through modes unless sequencer disable applies directly
module rx_baseband_control (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // register port
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // receive path inputs (asynchronous)
   input  wire        demod_data,
   input  wire        signal_threshold_flag,
   // converter results
   input  wire [7:0]  phase_error,
   input  wire [7:0]  temperature_adc,
   // recovered stream outputs
   output reg         recovered_data,
   output reg         recovered_clock_pin,
   // block enables, filter choice and timeout interrupt
   output reg  [2:0]  active_mode,
   output reg         periodic_wake_active,
   output reg         use_correction_bandwidth,
   output reg         temperature_adc_enable,
   output reg         timeout_irq
);
   // settings and results
   reg [7:0]  operating_mode_setting;
   reg [7:0]  bit_rate_high_byte;
   reg [7:0]  bit_rate_low_byte;
   reg        auto_correction_enable;
   reg        correction_auto_clear;
   reg        low_index_correction_enable;
   reg [7:0]  low_index_offset_code;
   reg [23:0] carrier_freq;
   reg [7:0]  correction_phase_bandwidth;
   reg [7:0]  receive_start_timeout_coef;
   reg [7:0]  threshold_timeout_coef;
   reg [15:0] frequency_error_value;
   reg [15:0] correction_value;
   reg [7:0]  temperature_value;
   reg        temperature_running;
   reg        correction_done;
   reg        fei_done;

   wire [2:0] mode_field = operating_mode_setting[`OPM_MODE_LSB +: 3];
   wire       continuous = operating_mode_setting[`OPM_CONTINUOUS_BIT];
   wire [15:0] bit_rate_setting = {bit_rate_high_byte, bit_rate_low_byte};

   // input synchronisers: stage one feeds stage two only
   reg [1:0] data_sync;
   reg [1:0] thresh_sync;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         data_sync   <= 2'b00;
         thresh_sync <= 2'b00;
      end else begin
         data_sync   <= {data_sync[0], demod_data};
         thresh_sync <= {thresh_sync[0], signal_threshold_flag};
      end
   end
   wire data_s   = data_sync[1];
   wire thresh_s = thresh_sync[1];
   reg  data_q;
   reg  thresh_q;

   // sync on in packet mode always, in continuous mode unless disabled
   wire sync_on = ~continuous | ~operating_mode_setting[`OPM_SYNC_OFF_BIT];

   // bit clock, realigned on each data edge while sync is on so it tracks the far rate
   wire data_edge = data_s ^ data_q;
   wire bit_tick;
   bit_period_timer u_bit_timer (
      .clk_sys (clk_sys),
      .rst     (rst),
      .divider (bit_rate_setting),
      .clear   (sync_on & data_edge),
      .tick    (bit_tick)
   );
   reg [15:0] half_count;

   // recovered stream: data sampled mid-bit while sync is on, clock high for the second half in continuous mode only
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         data_q              <= 1'b0;
         thresh_q            <= 1'b0;
         half_count          <= 16'h0000;
         recovered_data      <= 1'b0;
         recovered_clock_pin <= 1'b0;
      end else begin
         data_q   <= data_s;
         thresh_q <= thresh_s;
         if (!sync_on) begin
            recovered_data      <= data_s; // raw stream with sync disabled
            recovered_clock_pin <= 1'b0;
         end else if (data_edge || bit_tick) begin
            half_count          <= 16'h0000;
            recovered_clock_pin <= 1'b0;
         end else if (half_count == {1'b0, bit_rate_setting[15:1]}) begin
            half_count          <= half_count + 16'h0001;
            recovered_data      <= data_s; // glitch-free mid-bit sample
            recovered_clock_pin <= continuous;
         end else begin
            half_count <= half_count + 16'h0001;
         end
      end
   end

   // mode sequencer: wakes one level at a time up to synth, then jumps to target or down, unless disabled
   reg [15:0] seq_wait;
   wire       listen = operating_mode_setting[`OPM_LISTEN_BIT];
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         active_mode          <= `MODE_STANDBY;
         periodic_wake_active <= 1'b0;
         seq_wait             <= 16'h0000;
      end else begin
         periodic_wake_active <= listen;
         if (listen) begin
            seq_wait <= 16'h0000;
         end else if (operating_mode_setting[`OPM_SEQ_OFF_BIT] || mode_field > `MODE_RECEIVE) begin
            if (mode_field <= `MODE_RECEIVE)
               active_mode <= mode_field; // direct selection
         end else if (active_mode != mode_field) begin
            if (seq_wait != 16'h0000) begin
               seq_wait <= seq_wait - 16'h0001;
            end else begin
               seq_wait <= `SEQ_STEP_CYCLES;
               // sleep to standby to synth first, then target
               if (mode_field < active_mode || active_mode >= `MODE_SYNTH)
                  active_mode <= mode_field;
               else
                  active_mode <= active_mode + 3'h1;
            end
         end
      end
   end
   wire in_rx      = (active_mode == `MODE_RECEIVE) & ~listen;
   reg  in_rx_q;
   wire rx_entry   = in_rx & ~in_rx_q;

   // frequency error and correction engine
   reg        fei_busy;
   reg        fei_is_afc;
   reg [2:0]  fei_bits;
   reg signed [15:0] phase_acc;
   wire wr_cc = reg_wr && (reg_addr == `REG_CORRECTION_CONTROL);
   wire afc_req = (auto_correction_enable & rx_entry)
                | (wr_cc & reg_wdata[`CC_START_BIT] & ~auto_correction_enable);
   wire fei_req = wr_cc & reg_wdata[`CC_FEI_START_BIT];
   wire signed [15:0] low_off = low_index_correction_enable ? {8'h00, low_index_offset_code} : 16'h0000;
   wire [15:0] fei_new = phase_acc + {{8{phase_error[7]}}, phase_error};
   wire [15:0] afc_new = fei_new + low_off; // error plus offset in low index mode
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         in_rx_q                  <= 1'b0;
         fei_busy                 <= 1'b0;
         fei_is_afc               <= 1'b0;
         fei_bits                 <= 3'h0;
         phase_acc                <= 16'h0000;
         frequency_error_value    <= 16'h0000;
         correction_value         <= 16'h0000;
         carrier_freq             <= `CARRIER_RESET;
         use_correction_bandwidth <= 1'b0;
         correction_done          <= 1'b0;
         fei_done                 <= 1'b0;
      end else begin
         in_rx_q <= in_rx;
         if (!fei_busy && (afc_req || fei_req)) begin
            fei_busy                 <= 1'b1;
            fei_is_afc               <= afc_req;
            fei_bits                 <= 3'h0;
            phase_acc                <= 16'h0000;
            use_correction_bandwidth <= afc_req;
            if (afc_req) begin
               correction_done <= 1'b0;
               if (auto_correction_enable && correction_auto_clear) begin
                  carrier_freq     <= carrier_freq + {{8{correction_value[15]}}, correction_value}; // undo old
                  correction_value <= 16'h0000;
               end
            end else begin
               fei_done <= 1'b0;
            end
         end else if (fei_busy && bit_tick) begin
            fei_bits  <= fei_bits + 3'h1;
            phase_acc <= fei_new;
            if (fei_bits == `FEI_BIT_PERIODS - 1) begin // four bit periods
               fei_busy                 <= 1'b0;
               use_correction_bandwidth <= 1'b0;
               frequency_error_value    <= fei_new; // signed two's complement in synth steps
               fei_done                 <= 1'b1;
               if (fei_is_afc) begin
                  correction_value <= afc_new;
                  carrier_freq     <= carrier_freq - {{8{afc_new[15]}}, afc_new};
                  correction_done  <= 1'b1;
               end
            end
         end
      end
   end

   // temperature measurement: only from standby or synth
   reg [15:0] temp_count;
   wire temp_ok  = (active_mode == `MODE_STANDBY || active_mode == `MODE_SYNTH) & ~listen;
   wire temp_req = wr_cc & reg_wdata[`CC_TEMP_START_BIT] & temp_ok;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         temperature_running    <= 1'b0;
         temperature_adc_enable <= 1'b0;
         temp_count             <= 16'h0000;
         temperature_value      <= `TEMP_RESET;
      end else if (temp_req && !temperature_running) begin
         temperature_running    <= 1'b1;
         temperature_adc_enable <= 1'b1; // converter borrowed from receiver
         temp_count             <= 16'h0000;
      end else if (temperature_running) begin
         temp_count <= temp_count + 16'h0001;
         if (temp_count == 16'h0020) begin // far inside the limit
            temperature_value      <= temperature_adc; // converter already falls with heat
            temperature_running    <= 1'b0;
            temperature_adc_enable <= 1'b0;
         end
      end
   end

   // receive timeouts counted in 16-bit blocks
   reg [3:0]  tmo_sub;
   reg [7:0]  tmo_blocks;
   reg        tmo_phase;
   wire [7:0] tmo_coef = tmo_phase ? threshold_timeout_coef : receive_start_timeout_coef;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tmo_sub     <= 4'h0;
         tmo_blocks  <= 8'h00;
         tmo_phase   <= 1'b0;
         timeout_irq <= 1'b0;
      end else if (!in_rx || rx_entry) begin
         tmo_sub     <= 4'h0;
         tmo_blocks  <= 8'h00;
         tmo_phase   <= 1'b0;
         timeout_irq <= 1'b0;
      end else if (thresh_s && !thresh_q && !tmo_phase) begin
         tmo_phase  <= 1'b1; // restart from threshold rise
         tmo_sub    <= 4'h0;
         tmo_blocks <= 8'h00;
      end else if (bit_tick && tmo_coef != 8'h00 && !timeout_irq) begin // zero disables
         tmo_sub <= tmo_sub + 4'h1;
         if (tmo_sub == `TIMEOUT_BIT_MULT - 1) begin
            tmo_blocks <= tmo_blocks + 8'h01;
            if (tmo_blocks + 8'h01 == tmo_coef)
               timeout_irq <= 1'b1;
         end
      end
   end

   // register writes
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         operating_mode_setting      <= `OPM_RESET;
         bit_rate_high_byte          <= `BIT_RATE_HIGH_RESET;
         bit_rate_low_byte           <= `BIT_RATE_LOW_RESET;
         auto_correction_enable      <= 1'b0;
         correction_auto_clear       <= 1'b0;
         low_index_correction_enable <= 1'b0;
         low_index_offset_code       <= 8'h00;
         correction_phase_bandwidth  <= 8'h8B;
         receive_start_timeout_coef  <= 8'h00;
         threshold_timeout_coef      <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_OPERATING_MODE: operating_mode_setting <= reg_wdata[7:0];
            `REG_BIT_RATE: begin
               bit_rate_high_byte <= reg_wdata[15:8];
               bit_rate_low_byte  <= reg_wdata[7:0];
            end
            `REG_CORRECTION_CONTROL: begin
               auto_correction_enable <= reg_wdata[`CC_AUTO_ON_BIT];
               correction_auto_clear  <= reg_wdata[`CC_AUTO_CLEAR_BIT];
            end
            `REG_CORRECTION_MODE:  low_index_correction_enable <= reg_wdata[`CM_LOW_INDEX_BIT];
            `REG_LOW_INDEX_OFFSET: low_index_offset_code <= reg_wdata[7:0];
            `REG_BANDWIDTH:        correction_phase_bandwidth <= reg_wdata[7:0];
            `REG_TIMEOUT: begin
               receive_start_timeout_coef <= reg_wdata[7:0];
               threshold_timeout_coef     <= reg_wdata[15:8];
            end
            default: ;
         endcase
      end
   end

   // read data, valid the cycle after the strobe only
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_OPERATING_MODE:     reg_rdata <= {24'h00_0000, operating_mode_setting};
            `REG_BIT_RATE:           reg_rdata <= {16'h0000, bit_rate_setting};
            `REG_CORRECTION_CONTROL: reg_rdata <= {26'h000_0000, correction_done, fei_busy,
                                                   2'b00, correction_auto_clear, auto_correction_enable};
            `REG_FREQ_ERROR_RESULT:  reg_rdata <= {15'h0000, fei_done, frequency_error_value};
            `REG_CORRECTION_VALUE:   reg_rdata <= {16'h0000, correction_value};
            `REG_CORRECTION_MODE:    reg_rdata <= {31'h0000_0000, low_index_correction_enable};
            `REG_LOW_INDEX_OFFSET:   reg_rdata <= {24'h00_0000, low_index_offset_code};
            `REG_CARRIER_FREQ:       reg_rdata <= {8'h00, carrier_freq};
            `REG_TEMPERATURE:        reg_rdata <= {23'h00_0000, temperature_running, temperature_value};
            `REG_TIMEOUT:            reg_rdata <= {16'h0000, threshold_timeout_coef, receive_start_timeout_coef};
            `REG_STATUS:             reg_rdata <= {26'h000_0000, thresh_s, timeout_irq,
                                                   periodic_wake_active, active_mode};
            `REG_BANDWIDTH:          reg_rdata <= {24'h00_0000, correction_phase_bandwidth};
            default:                 reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule

//--- dv/rx_baseband_control_sva.sv
// Purpose: port checks for the receive baseband control block
// Assumes: settings shadowed from register writes
// Notes:   checks wait a few cycles after a mode write
`timescale 1ns/100ps
`include "rx_baseband_control_defines.vh"
module rx_baseband_control_sva (
   // clock and reset
   input logic        clk_sys,
   input logic        rst,
   // register writes
   input logic [3:0]  reg_addr,
   input logic [31:0] reg_wdata,
   input logic        reg_wr,
   // observed outputs
   input logic        recovered_clock_pin,
   input logic [2:0]  active_mode,
   input logic        periodic_wake_active,
   input logic        use_correction_bandwidth,
   input logic        temperature_adc_enable,
   input logic        timeout_irq
);
   logic [7:0]  opm;
   logic [15:0] br;
   logic [15:0] tmo;
   logic [9:0]  age;
   logic [15:0] crun;
   // shadows, age of the last mode write, correction window length
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         opm  <= 8'h01;
         br   <= 16'h001a;
         tmo  <= 16'h0000;
         age  <= 10'h000;
         crun <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == `REG_OPERATING_MODE) begin
            opm <= reg_wdata[7:0];
            age <= 10'h000;
         end else if (age != 10'h3ff) begin
            age <= age + 10'h001; // saturates so long idle spells stay guarded
         end
         if (reg_wr && reg_addr == `REG_BIT_RATE) br <= reg_wdata[15:0];
         if (reg_wr && reg_addr == `REG_TIMEOUT) tmo <= reg_wdata[15:0];
         crun <= use_correction_bandwidth ? crun + 16'h0001 : 16'h0000;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // wake steps of the sequencer from sleep
   sequence s_to_standby;
      ##[1:8] active_mode == `MODE_STANDBY;
   endsequence
   sequence s_to_synth;
      ##[50:80] active_mode == `MODE_SYNTH;
   endsequence
   a_direct_mode:
      assert property (age >= 3 && opm[4] && !opm[3] |-> active_mode == opm[2:0])
      else $error("mode not applied directly");
   a_seq_first_step:
      assert property (reg_wr && reg_addr == `REG_OPERATING_MODE && reg_wdata[4:0] == 5'h04 &&
                       active_mode == `MODE_SLEEP |-> s_to_standby ##0 s_to_synth)
      else $error("no stepped wake");
   a_seq_settle:
      assert property (age >= 260 && !opm[3] |-> active_mode == opm[2:0])
      else $error("requested mode not reached");
   a_listen_follow:
      assert property (age >= 3 |-> periodic_wake_active == opm[3])
      else $error("periodic wake does not follow its bit");
   a_clock_gate:
      assert property (age >= 4 && !(opm[5] && !opm[6]) |=> $stable(recovered_clock_pin))
      else $error("recovered clock moves when gated");
   a_meas_length:
      assert property ($fell(use_correction_bandwidth) |-> $past(crun) >= 3 * br && $past(crun) <= 4 * br + 8)
      else $error("measurement window length wrong");
   a_temp_duration:
      assert property ($rose(temperature_adc_enable) |-> temperature_adc_enable[*8] ##[1:32] !temperature_adc_enable)
      else $error("temperature run length wrong");
   a_temp_mode_gate:
      assert property ($rose(temperature_adc_enable) |-> $past(active_mode) inside {`MODE_STANDBY, `MODE_SYNTH})
      else $error("temperature run in wrong mode");
   a_timeout_zero_off:
      assert property (tmo == 16'h0000 |-> !$rose(timeout_irq))
      else $error("timeout raised with zero coefficients");
endmodule
bind rx_baseband_control rx_baseband_control_sva sva_u (.*);

//--- dv/tx_link_model.sv
// Purpose: far transmitter feeding demodulated bits at a 125 ns bit period
// Assumes: alternating preamble first, then a payload with short runs
// Notes:   link clock stands still between frames; data inverts when idle
`timescale 1ns/100ps
module tx_link_model (
   // frame control
   input  logic enable,
   // link side
   output logic link_clk,
   output logic demod_data
);
   localparam logic [15:0] payload_bits = 16'hf0c3;
   int n;
   // idle line inverts so a stale value never looks valid
   initial begin
      link_clk   = 1'b0;
      demod_data = 1'b0;
      forever begin
         wait (enable);
         for (n = 0; enable; n++) begin
            demod_data = (n < 16) ? n[0] : payload_bits[n[3:0]];
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
         end
         demod_data = ~demod_data;
      end
   end
endmodule

//--- dv/rx_baseband_control_tb.sv
// Purpose: directed bench for the receive baseband control block
// Assumes: divider 31 clocks per bit against a 125 ns link bit
// Notes:   expected values come from the register map and signed phase sums
`timescale 1ns/100ps
`include "rx_baseband_control_defines.vh"
module rx_baseband_control_tb;
   logic        clk_sys, rst, reg_wr, reg_rd, demod_data, link_clk, link_en, signal_threshold_flag;
   logic        recovered_data, recovered_clock_pin, periodic_wake_active, use_correction_bandwidth;
   logic        temperature_adc_enable, timeout_irq, saw_cbw, saw_ten;
   logic [2:0]  active_mode;
   logic [3:0]  reg_addr;
   logic [7:0]  phase_error, temperature_adc;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   int          n_mismatch, total_checks, cycles, toggles, i, k;
   rx_baseband_control dut_u (.*);
   tx_link_model link_u (.enable(link_en), .link_clk(link_clk), .demod_data(demod_data));
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // hang guard and sticky observation flags
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (use_correction_bandwidth === 1'b1) saw_cbw <= 1'b1;
      if (temperature_adc_enable === 1'b1) saw_ten <= 1'b1;
      if (cycles == 60000) begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end
   always @(recovered_clock_pin) toggles = toggles + 1;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      rd(a, rd_val);
      chk(rd_val, exp);
   endtask
   task automatic poll(input logic [3:0] a, input logic [31:0] old);
      rd_val = old;
      for (k = 0; k < 300 && rd_val === old; k++) rd(a, rd_val);
   endtask
   task automatic enter_rx();
      wr(`REG_OPERATING_MODE, 32'h11);
      waitc(4);
      wr(`REG_OPERATING_MODE, 32'h14);
   endtask
   // main sequence
   initial begin
      rst = 1'b1; reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0; link_en = 1'b0;
      signal_threshold_flag = 1'b0; phase_error = 8'hfd; temperature_adc = 8'h5a;
      n_mismatch = 0; total_checks = 0; cycles = 0; toggles = 0; saw_cbw = 1'b0; saw_ten = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rchk(`REG_OPERATING_MODE, 32'h1);
      rchk(`REG_BIT_RATE, 32'h1a);
      rchk(`REG_CARRIER_FREQ, 32'he4_c000);
      rchk(4'hf, 32'h0);
      $display("test reset_values done");
      for (i = 0; i < 5; i++) begin
         wr(`REG_OPERATING_MODE, 32'h10 | i);
         waitc(4);
         chk(active_mode, i);
      end
      wr(`REG_OPERATING_MODE, 32'h19);
      waitc(4);
      chk(periodic_wake_active, 32'h1);
      wr(`REG_OPERATING_MODE, 32'h10);
      waitc(4);
      wr(`REG_OPERATING_MODE, 32'h04);
      waitc(100);
      chk(active_mode, `MODE_SYNTH);
      waitc(200);
      chk(active_mode, `MODE_RECEIVE);
      $display("test modes done");
      wr(`REG_OPERATING_MODE, 32'h11);
      waitc(4);
      saw_ten = 1'b0;
      wr(`REG_CORRECTION_CONTROL, 32'h10);
      waitc(50);
      chk(saw_ten, 32'h1);
      rchk(`REG_TEMPERATURE, 32'h5a);
      wr(`REG_OPERATING_MODE, 32'h14);
      waitc(4);
      saw_ten = 1'b0;
      wr(`REG_CORRECTION_CONTROL, 32'h10);
      waitc(50);
      chk(saw_ten, 32'h0);
      $display("test temperature done");
      wr(`REG_BIT_RATE, 32'h1f);
      link_en <= 1'b1;
      wr(`REG_CORRECTION_CONTROL, 32'h08);
      rd_val = 32'h0;
      for (k = 0; k < 300 && rd_val[16] !== 1'b1; k++) rd(`REG_FREQ_ERROR_RESULT, rd_val);
      chk(rd_val, 32'h1_fff4);
      wr(`REG_CORRECTION_CONTROL, 32'h01);
      poll(`REG_CARRIER_FREQ, 32'he4_c000);
      chk(rd_val, 32'he4_c00c);
      chk(saw_cbw, 32'h1);
      wr(`REG_CORRECTION_MODE, 32'h1);
      wr(`REG_LOW_INDEX_OFFSET, 32'h5);
      wr(`REG_CORRECTION_CONTROL, 32'h01);
      poll(`REG_CARRIER_FREQ, 32'he4_c00c);
      chk(rd_val, 32'he4_c013);
      wr(`REG_CORRECTION_MODE, 32'h0);
      wr(`REG_CORRECTION_CONTROL, 32'h02);
      enter_rx();
      poll(`REG_CARRIER_FREQ, 32'he4_c013);
      chk(rd_val, 32'he4_c01f);
      wr(`REG_CORRECTION_CONTROL, 32'h06);
      enter_rx();
      waitc(400);
      rchk(`REG_CARRIER_FREQ, 32'he4_c01f);
      $display("test correction done");
      wr(`REG_CORRECTION_CONTROL, 32'h00);
      wr(`REG_TIMEOUT, 32'h01);
      enter_rx();
      waitc(430);
      chk(timeout_irq, 32'h0);
      waitc(130);
      chk(timeout_irq, 32'h1);
      wr(`REG_TIMEOUT, 32'h0100);
      enter_rx();
      waitc(20);
      signal_threshold_flag <= 1'b1;
      waitc(430);
      chk(timeout_irq, 32'h0);
      waitc(130);
      chk(timeout_irq, 32'h1);
      signal_threshold_flag <= 1'b0;
      wr(`REG_TIMEOUT, 32'h0);
      enter_rx();
      waitc(1200);
      chk(timeout_irq, 32'h0);
      $display("test timeouts done");
      wr(`REG_OPERATING_MODE, 32'h34);
      waitc(100);
      toggles = 0;
      waitc(1240);
      chk(toggles >= 60 && toggles <= 100, 32'h1);
      wr(`REG_OPERATING_MODE, 32'h74);
      waitc(20);
      toggles = 0;
      waitc(620);
      chk(toggles, 32'h0);
      $display("test continuous done");
      report_and_stop();
   end
endmodule
